// *** verilog/almp_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module almp_ctrl #(
  parameter int SAMPLE_W = 16,
  parameter int RAMP_W   = 20
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 cw_load,
  input  wire logic [63:0]          cw_data,
  output logic      [63:0]          cw_readback,
  input  wire logic                 word_clk_tick,
  input  wire logic                 clip,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [SAMPLE_W-1:0]  in_left,
  input  wire logic [SAMPLE_W-1:0]  in_right,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic      [SAMPLE_W-1:0]  out_left,
  output logic      [SAMPLE_W-1:0]  out_right,
  output logic      [5:0]           gain_atten,
  output logic                      gain_step,
  output logic                      hbridge_drive_en,
  output logic      [4:0]           pcomp,
  output logic      [4:0]           ncomp,
  output logic                      auto_low_power,
  input  wire logic                 silence_detect,
  output logic                      digital_silence,
  output logic                      pwm_high_rate,
  output logic                      pwm_method,
  output almp_pkg::almp_pwm_t       pwm_mode
);
  typedef enum logic [2:0] {
    ALMP_IDLE    = 3'b001,
    ALMP_ATTACK  = 3'b010,
    ALMP_RELEASE = 3'b100
  } almp_lim_t;

  typedef struct packed {
    logic [63:0]       cw;
    almp_lim_t         lim;
    logic [RAMP_W-1:0] cnt;
    logic [5:0]        atten;
    logic              step;
    logic              silent;
    logic [SAMPLE_W-1:0] ol;
    logic [SAMPLE_W-1:0] orr;
    logic              ov;
  } almp_st_t;

  almp_st_t s_q, s_d;
  almp_pkg::almp_cfg_t cfg;
  almp_pkg::almp_pair_t mixed, buf_out;
  logic [RAMP_W-1:0] atk_len, rel_len;
  logic buf_valid, buf_ready;

  // reset image of the control word
  function automatic logic [63:0] cw_reset();
    logic [63:0] w;
    w = '0;
    w[almp_pkg::ATK_LSB +: almp_pkg::ATK_W]      = almp_pkg::ATK_RST;
    w[almp_pkg::REL_LSB +: almp_pkg::REL_W]      = almp_pkg::REL_RST;
    w[almp_pkg::MIX_LSB +: almp_pkg::MIX_W]      = almp_pkg::MIX_RST;
    w[almp_pkg::HBON_BIT]                        = 1'b0;
    w[almp_pkg::PCOMP_LSB +: almp_pkg::COMP_W]   = almp_pkg::PCOMP_RST;
    w[almp_pkg::NCOMP_LSB +: almp_pkg::COMP_W]   = almp_pkg::NCOMP_RST;
    return w;
  endfunction : cw_reset

  // field extraction
  assign cfg.atk    = s_q.cw[almp_pkg::ATK_LSB +: almp_pkg::ATK_W];
  assign cfg.rel    = s_q.cw[almp_pkg::REL_LSB +: almp_pkg::REL_W];
  assign cfg.mix    = s_q.cw[almp_pkg::MIX_LSB +: almp_pkg::MIX_W];
  assign cfg.hbon   = s_q.cw[almp_pkg::HBON_BIT];
  assign cfg.pcomp  = s_q.cw[almp_pkg::PCOMP_LSB +: almp_pkg::COMP_W];
  assign cfg.ncomp  = s_q.cw[almp_pkg::NCOMP_LSB +: almp_pkg::COMP_W];
  assign cfg.alp    = s_q.cw[almp_pkg::ALP_BIT];
  assign cfg.rate   = s_q.cw[almp_pkg::RATE_BIT];
  assign cfg.method = s_q.cw[almp_pkg::METHOD_BIT];

  // step lengths: 4^code and 16*2^code word clocks
  assign atk_len = RAMP_W'(1) << (cfg.atk * almp_pkg::ATK_SHIFT);
  assign rel_len = RAMP_W'(1) << (cfg.rel + almp_pkg::REL_BASE_SH);

  assign cw_readback      = s_q.cw;
  assign hbridge_drive_en = cfg.hbon;
  assign pcomp            = cfg.pcomp;
  assign ncomp            = cfg.ncomp;
  assign auto_low_power   = cfg.alp;
  assign pwm_high_rate    = cfg.rate;
  assign pwm_method       = cfg.method;
  assign pwm_mode         = almp_pkg::almp_pwm_t'({cfg.rate, cfg.method});
  assign gain_atten       = s_q.atten;
  assign gain_step        = s_q.step;
  assign digital_silence  = s_q.silent;

  almp_mix #(
    .W(SAMPLE_W)
  ) u_mix (
    .mix     (cfg.mix),
    .in_pair ({in_left, in_right}),
    .out_pair(mixed)
  );

  // stall protection between mixer and output register
  almp_buf #(
    .W(2 * SAMPLE_W)
  ) u_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .in_valid (in_valid),
    .in_ready (in_ready),
    .in_data  (mixed),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data (buf_out)
  );

  // output stage holds data until taken
  assign buf_ready = !s_q.ov || out_ready;
  assign out_valid = s_q.ov;
  assign out_left  = s_q.ol;
  assign out_right = s_q.orr;

  // next-state logic: control word, limiter ramp, output stage
  always_comb begin
    logic [RAMP_W-1:0] len;
    len = '0;
    s_d = s_q;
    s_d.step = 1'b0;
    if (cw_load) begin
      s_d.cw = cw_data;
    end
    // silence only honoured while auto low power is on
    s_d.silent = cfg.alp && silence_detect;
    unique case (s_q.lim)
      ALMP_IDLE: begin
        s_d.cnt = '0;
        if (clip && s_q.atten != almp_pkg::GAIN_MAX) begin
          s_d.lim = ALMP_ATTACK;
        end else if (!clip && s_q.atten != 6'h0) begin
          s_d.lim = ALMP_RELEASE;
        end
      end
      ALMP_ATTACK: begin
        len = atk_len;
        if (!clip) begin
          s_d.lim = ALMP_RELEASE; // clip over, start recovery
          s_d.cnt = '0;
        end else if (word_clk_tick) begin
          if (s_q.cnt + RAMP_W'(1) >= len) begin
            s_d.cnt   = '0;
            s_d.atten = s_q.atten + 6'h1;
            s_d.step  = 1'b1;
            if (s_q.atten + 6'h1 == almp_pkg::GAIN_MAX) begin
              s_d.lim = ALMP_IDLE;
            end
          end else begin
            s_d.cnt = s_q.cnt + RAMP_W'(1);
          end
        end
      end
      ALMP_RELEASE: begin
        len = rel_len;
        if (clip) begin
          s_d.lim = ALMP_ATTACK;
          s_d.cnt = '0;
        end else if (word_clk_tick) begin
          if (s_q.cnt + RAMP_W'(1) >= len) begin
            s_d.cnt   = '0;
            s_d.atten = s_q.atten - 6'h1;
            s_d.step  = 1'b1;
            if (s_q.atten == 6'h1) begin
              s_d.lim = ALMP_IDLE;
            end
          end else begin
            s_d.cnt = s_q.cnt + RAMP_W'(1);
          end
        end
      end
      default: begin
        s_d.lim = ALMP_IDLE;
      end
    endcase
    if (buf_valid && buf_ready) begin
      s_d.ov  = 1'b1;
      s_d.ol  = buf_out.left;
      s_d.orr = buf_out.right;
    end else if (out_ready) begin
      s_d.ov = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.cw  <= cw_reset();
      s_q.lim <= ALMP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : almp_ctrl
`default_nettype wire

// *** verilog/almp_pkg.sv ***
`default_nettype none
package almp_pkg;
  // control word layout
  localparam int CW_W        = 64;
  localparam int ATK_LSB     = 37;
  localparam int ATK_W       = 3;
  localparam int REL_LSB     = 40;
  localparam int REL_W       = 4;
  localparam int MIX_LSB     = 46;
  localparam int MIX_W       = 4;
  localparam int HBON_BIT    = 50;
  localparam int PCOMP_LSB   = 51;
  localparam int NCOMP_LSB   = 56;
  localparam int COMP_W      = 5;
  localparam int ALP_BIT     = 61;
  localparam int RATE_BIT    = 62;
  localparam int METHOD_BIT  = 63;
  // reset values
  localparam logic [2:0] ATK_RST    = 3'h1;
  localparam logic [3:0] REL_RST    = 4'ha;
  localparam logic [3:0] MIX_RST    = 4'h9;
  localparam logic [4:0] PCOMP_RST  = 5'h10;
  localparam logic [4:0] NCOMP_RST  = 5'h00;
  // ramp counts
  localparam int RAMP_W      = 20;
  localparam int ATK_SHIFT   = 2;
  localparam int REL_BASE_SH = 4;
  localparam logic [5:0] GAIN_MAX = 6'h3f;
  localparam int SAMPLE_W    = 16;

  typedef enum logic [1:0] {
    ALMP_SRC_MUTE  = 2'h0,
    ALMP_SRC_RIGHT = 2'h1,
    ALMP_SRC_LEFT  = 2'h2,
    ALMP_SRC_AVG   = 2'h3
  } almp_src_t;

  typedef enum logic [1:0] {
    ALMP_PWM_R500K = 2'h0,
    ALMP_PWM_H1M   = 2'h1,
    ALMP_PWM_R1M   = 2'h2,
    ALMP_PWM_H2M   = 2'h3
  } almp_pwm_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } almp_pair_t;

  typedef struct packed {
    logic [2:0] atk;
    logic [3:0] rel;
    logic [3:0] mix;
    logic       hbon;
    logic [4:0] pcomp;
    logic [4:0] ncomp;
    logic       alp;
    logic       rate;
    logic       method;
  } almp_cfg_t;
endpackage : almp_pkg
`default_nettype wire

// *** verilog/almp_mix.sv ***
`timescale 1ns/10ps
`default_nettype none
module almp_mix #(
  parameter int W = 16
) (
  input  wire logic       [3:0] mix,
  input  wire almp_pkg::almp_pair_t in_pair,
  output almp_pkg::almp_pair_t    out_pair
);
  // one source picker serves both channels
  function automatic logic [W-1:0] pick(input logic [1:0] sel, input logic [W-1:0] l, input logic [W-1:0] r);
    logic [W:0] sum;
    sum = {l[W-1], l} + {r[W-1], r};
    unique case (sel)
      2'h0: pick = '0;
      2'h1: pick = r;
      2'h2: pick = l;
      2'h3: pick = sum[W:1]; // arithmetic average, no overflow
    endcase
  endfunction : pick

  // upper pair drives left, lower pair drives right
  assign out_pair.left  = pick(mix[3:2], in_pair.left, in_pair.right);
  assign out_pair.right = pick(mix[1:0], in_pair.left, in_pair.right);
endmodule : almp_mix
`default_nettype wire

// *** verilog/almp_buf.sv ***
`timescale 1ns/10ps
`default_nettype none
module almp_buf #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } almp_buf_st_t;

  almp_buf_st_t s_q, s_d;

  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rd];

  // two-entry ring, push and pop may share a cycle
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    s_d  = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : almp_buf
`default_nettype wire

// *** tb/almp_ctrl_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module almp_ctrl_asserts #(
  parameter int SAMPLE_W = 16,
  parameter int RAMP_W   = 20
) (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                cw_load,
  input wire logic [63:0]         cw_data,
  input wire logic [63:0]         cw_readback,
  input wire logic                word_clk_tick,
  input wire logic                clip,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire logic [SAMPLE_W-1:0] out_left,
  input wire logic [SAMPLE_W-1:0] out_right,
  input wire logic [5:0]          gain_atten,
  input wire logic                gain_step,
  input wire logic                hbridge_drive_en,
  input wire logic [4:0]          pcomp,
  input wire logic [4:0]          ncomp,
  input wire logic                auto_low_power,
  input wire logic                silence_detect,
  input wire logic                digital_silence,
  input wire logic                pwm_high_rate,
  input wire logic                pwm_method,
  input wire almp_pkg::almp_pwm_t pwm_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // stored word follows a load one cycle later
  chk_cw_take: assert property (cw_load |=> cw_readback == $past(cw_data))
    else $error("control word not taken");
  // decoded outputs must track their bits
  chk_bridge_gate: assert property (hbridge_drive_en == cw_readback[50])
    else $error("bridge enable off its bit");
  chk_comp_fields: assert property ({ncomp, pcomp} == cw_readback[60:51])
    else $error("compensation fields off");
  chk_pwm_mode: assert property ({pwm_mode, pwm_high_rate, pwm_method} == {2{cw_readback[62], cw_readback[63]}})
    else $error("pwm selection off");
  chk_silence_gate: assert property (auto_low_power == cw_readback[61]
    && digital_silence == $past(auto_low_power && silence_detect))
    else $error("silence not gated by low power");
  // one tick of slack allows a registered tick inside
  chk_step_tick: assert property (!word_clk_tick && !$past(word_clk_tick) |=> $stable(gain_atten))
    else $error("gain moved without a word tick");
  // a step pulse always comes with a moved attenuation
  chk_step_pulse: assert property (gain_step |-> gain_atten != $past(gain_atten))
    else $error("step pulse without gain change");
  chk_attack_dir: assert property (clip && $past(clip) && $past(clip, 2) |-> gain_atten >= $past(gain_atten))
    else $error("gain raised while clipping");
  chk_release_dir: assert property (!clip && !$past(clip) && !$past(clip, 2) |-> gain_atten <= $past(gain_atten))
    else $error("gain lowered after clip");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable({out_left, out_right}))
    else $error("output word dropped under stall");
  cov_step: cover property (gain_step);
  cov_stall: cover property (out_valid && !out_ready);
  cov_silence: cover property (digital_silence);
endmodule : almp_ctrl_asserts
`default_nettype wire

// *** tb/almp_sink.sv ***
`timescale 1ns/10ps
`default_nettype none
module almp_sink (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [15:0] out_left,
  input  wire logic [15:0] out_right
);
  almp_pkg::almp_pair_t got_q[$];
  // slow mode accepts every other cycle to stress the buffer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) got_q.push_back({out_left, out_right});
      out_ready <= !stall && (!slow || !out_ready);
    end
  end
endmodule : almp_sink
`default_nettype wire

// *** tb/almp_ctrl_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module almp_ctrl_bench;
  logic clk = 1'b0, sys_rst = 1'b1, cw_load = 1'b0, word_clk_tick = 1'b0, clip = 1'b0;
  logic in_valid = 1'b0, silence_detect = 1'b0, stall = 1'b0, slow = 1'b0, full_seen = 1'b0;
  logic [63:0] cw_data = '0, cw, cw_readback;
  logic [15:0] in_left = '0, in_right = '0, out_left, out_right;
  logic in_ready, out_valid, out_ready, hbridge_drive_en, auto_low_power, digital_silence;
  logic pwm_high_rate, pwm_method, gain_step;
  logic [5:0] gain_atten;
  logic [4:0] pcomp, ncomp;
  almp_pkg::almp_pwm_t pwm_mode;
  almp_pkg::almp_pair_t p;
  almp_pkg::almp_pwm_t pm_exp [4] = '{almp_pkg::ALMP_PWM_R500K, almp_pkg::ALMP_PWM_R1M,
                                     almp_pkg::ALMP_PWM_H1M, almp_pkg::ALMP_PWM_H2M};
  int n_fail = 0, check_count = 0, cyc = 0;

  always #20 clk = ~clk;

  almp_ctrl DUT (.clk, .sys_rst, .cw_load, .cw_data, .cw_readback, .word_clk_tick, .clip,
    .in_valid, .in_ready, .in_left, .in_right, .out_valid, .out_ready, .out_left, .out_right,
    .gain_atten, .gain_step, .hbridge_drive_en, .pcomp, .ncomp, .auto_low_power,
    .silence_detect, .digital_silence, .pwm_high_rate, .pwm_method, .pwm_mode);
  almp_sink u_sink (.clk, .sys_rst, .stall, .slow, .out_valid, .out_ready, .out_left, .out_right);

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // load a word; returns once the decoded outputs have settled
  task automatic wr(input logic [63:0] v);
    @(posedge clk) cw_load <= 1'b1;
    cw_data <= v;
    @(posedge clk) cw_load <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : wr

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk) word_clk_tick <= 1'b1;
      @(posedge clk) word_clk_tick <= 1'b0;
      @(posedge clk);
    end
    @(negedge clk);
  endtask : tk

  // hold valid and data until ready is seen at a sampling edge
  task automatic send(input logic [15:0] l, input logic [15:0] r);
    @(posedge clk) in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    @(negedge clk);
    while (in_ready !== 1'b1) begin
      full_seen = 1'b1;
      @(negedge clk);
    end
    @(posedge clk) in_valid <= 1'b0;
  endtask : send

  task automatic rx(input logic [15:0] l, input logic [15:0] r);
    repeat (20) if (u_sink.got_q.size() == 0) @(posedge clk);
    chk(64'(u_sink.got_q.size() > 0), 64'h1);
    p = u_sink.got_q.size() > 0 ? u_sink.got_q.pop_front() : '0;
    chk({p.left, p.right}, {l, r});
  endtask : rx

  function automatic logic [15:0] src(input logic [1:0] s);
    // mute, right, left, average of 1234 and 0456
    return s == 2'h0 ? 16'h0000 : s == 2'h1 ? 16'h0456 : s == 2'h2 ? 16'h1234 : 16'h0b45;
  endfunction : src

  // hang guard, well above the ramp tests
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    cw = '0;
    cw[39:37] = 3'h1;
    cw[43:40] = 4'ha;
    cw[49:46] = 4'h9;
    cw[55:51] = 5'h10;
    chk(cw_readback, cw);
    chk({hbridge_drive_en, pcomp, ncomp, gain_atten}, {1'b0, 5'h10, 5'h00, 6'h00});
    for (int i = 0; i < 4; i++) begin
      cw[63:62] = i[1:0];
      wr(cw);
      chk(pwm_mode, pm_exp[i]);
      chk({pwm_high_rate, pwm_method}, {i[0], i[1]});
    end
    cw[63:62] = 2'h2;
    cw[50] = 1'b1;
    wr(cw);
    chk(hbridge_drive_en, 1'b1);
    silence_detect <= 1'b1;
    wr(cw);
    chk(digital_silence, 1'b0);
    cw[61] = 1'b1;
    wr(cw);
    chk({auto_low_power, digital_silence}, 2'h3);
    for (int m = 0; m < 16; m++) begin
      cw[49:46] = m[3:0];
      wr(cw);
      send(16'h1234, 16'h0456);
      rx(src(m[3:2]), src(m[1:0]));
    end
    // receiver stalls for 30 cycles so the buffer refuses, then drains slowly
    stall <= 1'b1;
    fork
      for (int k = 0; k < 4; k++) send(16'h1234, 16'h0456);
      begin
        repeat (30) @(posedge clk);
        stall <= 1'b0;
        slow <= 1'b1;
      end
    join
    chk(full_seen, 1'b1);
    repeat (4) rx(16'h0b45, 16'h0b45);
    clip <= 1'b1;
    tk(8);
    chk(gain_atten, 6'h02);
    cw[39:37] = 3'h0;
    wr(cw);
    tk(5);
    chk(gain_atten, 6'h07);
    cw[39:37] = 3'h7;
    wr(cw);
    tk(16383);
    chk(gain_atten, 6'h07);
    tk(1);
    chk(gain_atten, 6'h08);
    cw[43:40] = 4'h0;
    wr(cw);
    clip <= 1'b0;
    tk(32);
    chk(gain_atten, 6'h06);
    close_out();
  end
endmodule : almp_ctrl_bench

bind almp_ctrl almp_ctrl_asserts #(.SAMPLE_W(SAMPLE_W), .RAMP_W(RAMP_W)) u_chk (.clk, .sys_rst,
  .cw_load, .cw_data, .cw_readback, .word_clk_tick, .clip, .out_valid, .out_ready, .out_left,
  .out_right, .gain_atten, .gain_step, .hbridge_drive_en, .pcomp, .ncomp, .auto_low_power,
  .silence_detect, .digital_silence, .pwm_high_rate, .pwm_method, .pwm_mode);
`default_nettype wire
